// File: logic/timer_pkg.sv
package timer_pkg;
   // Register byte offsets on the AXI4-Lite slave.
   localparam logic [3:0] CTRL_OFFS   = 4'h0;
   localparam logic [3:0] DATA_OFFS   = 4'h4;
   localparam logic [3:0] STATUS_OFFS = 4'h8;

   // Control word field positions.
   localparam int FMT_BIT     = 0;
   localparam int MODE_LSB    = 1;
   localparam int MODE_MSB    = 3;
   localparam int RW_LOW_BIT  = 4;
   localparam int RW_HIGH_BIT = 5;

   // Status field positions.
   localparam int ST_OUT_BIT  = 0;
   localparam int ST_PEND_BIT = 1;
   localparam int ST_CNT_LSB  = 16;

   // Counting modes.
   localparam logic [2:0] MODE_TC     = 3'h0;
   localparam logic [2:0] MODE_ONESHT = 3'h1;
   localparam logic [2:0] MODE_RATE   = 3'h2;
   localparam logic [2:0] MODE_SQUARE = 3'h3;
   localparam logic [2:0] MODE_SWSTRB = 3'h4;
   localparam logic [2:0] MODE_HWSTRB = 3'h5;

   // Byte access selections.
   localparam logic [1:0] RW_LATCH = 2'h0;
   localparam logic [1:0] RW_LOW   = 2'h1;
   localparam logic [1:0] RW_HIGH  = 2'h2;
   localparam logic [1:0] RW_BOTH  = 2'h3;

   // Reset values, half of the maximum count and bus response codes.
   localparam logic [15:0] COUNT_RST    = 16'h0000;
   localparam logic [15:0] HALF_MAX_BIN = 16'h8000;
   localparam logic [15:0] HALF_MAX_BCD = 16'h5000;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// File: logic/cnt_if.sv
`timescale 1ns/1ps
interface cnt_if;
   logic        load;
   logic [15:0] load_val;
   logic        dec;
   logic        bcd;
   logic [15:0] count;
   modport core (input load, load_val, dec, bcd, output count);
   modport ctl  (output load, load_val, dec, bcd, input count);
endinterface

// File: logic/down_counter.sv
`timescale 1ns/1ps
module down_counter
   import timer_pkg::*;
(
   input wire logic aclk,    // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   cnt_if.core      c        // Load and decrement control.
);

   logic [15:0] count_q;

   // Binary or four-digit decimal step down by one, wrapping at zero.
   function automatic logic [15:0] dec1(input logic [15:0] v,
                                        input logic        bcd);
      logic [15:0] r;
      logic        brw;
      r   = v;
      brw = 1'b1;
      if (!bcd) begin
         r = v - 16'h0001;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (brw) begin
               if (v[i*4 +: 4] == 4'h0) begin
                  r[i*4 +: 4] = 4'h9;
               end else begin
                  r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                  brw         = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= COUNT_RST;
      end else if (c.load) begin
         count_q <= c.load_val;
      end else if (c.dec) begin
         count_q <= dec1(count_q, c.bcd);
      end
   end

   assign c.count = count_q;

endmodule

// File: logic/interval_timer.sv
`timescale 1ns/1ps
module interval_timer
   import timer_pkg::*;
#(
   parameter int ADDR_W = 4
)(
   input  wire logic              aclk,      // System clock.
   input  wire logic              aresetn,   // Synchronous reset, low.
   input  wire logic [ADDR_W-1:0] awaddr,    // Write address.
   input  wire logic              awvalid,   // Write address valid.
   output      logic              awready,   // Write address ready.
   input  wire logic [31:0]       wdata,     // Write data.
   input  wire logic [3:0]        wstrb,     // Write byte enables.
   input  wire logic              wvalid,    // Write data valid.
   output      logic              wready,    // Write data ready.
   output      logic [1:0]        bresp,     // Write response.
   output      logic              bvalid,    // Write response valid.
   input  wire logic              bready,    // Write response ready.
   input  wire logic [ADDR_W-1:0] araddr,    // Read address.
   input  wire logic              arvalid,   // Read address valid.
   output      logic              arready,   // Read address ready.
   output      logic [31:0]       rdata,     // Read data.
   output      logic [1:0]        rresp,     // Read response.
   output      logic              rvalid,    // Read data valid.
   input  wire logic              rready,    // Read data ready.
   input  wire logic              count_clk, // Count clock input.
   input  wire logic              gate,      // Gate input.
   output      logic              timer_out  // Counter output.
);

   ////////////////////////////////////////////////////////////////////////
   // Bus slave.
   logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic              aw_held_q, w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0]        wbyte_q;
   logic              wlane_q;
   logic [1:0]        bresp_q, rresp_q;
   logic [31:0]       rdata_q;
   logic              wr_fire, rd_fire, ctrl_wr, data_wr, data_rd;

   assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
   assign rd_fire = arvalid & arready_q;
   assign ctrl_wr = wr_fire & wlane_q & (awaddr_q == CTRL_OFFS);
   assign data_wr = wr_fire & wlane_q & (awaddr_q == DATA_OFFS);
   assign data_rd = rd_fire & (araddr == DATA_OFFS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         aw_held_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (awvalid && awready_q) begin
         awready_q <= 1'b0;
         aw_held_q <= 1'b1;
         awaddr_q  <= awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end else if (bvalid_q && bready) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_q <= 1'b1;
         w_held_q <= 1'b0;
         wbyte_q  <= 8'h00;
         wlane_q  <= 1'b0;
      end else if (wvalid && wready_q) begin
         wready_q <= 1'b0;
         w_held_q <= 1'b1;
         wbyte_q  <= wdata[7:0];
         wlane_q  <= wstrb[0];
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end else if (bvalid_q && bready) begin
         wready_q <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (awaddr_q == CTRL_OFFS || awaddr_q == DATA_OFFS ||
                      awaddr_q == STATUS_OFFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter channel state.
   cnt_if c ();

   logic [2:0]  mode_q;
   logic        bcd_q, run_q, pend_q, halt_q, have_q, trig_q, out_q;
   logic        wr_hi_q, rd_hi_q, latched_q, ck_prev_q, gate_prev_q;
   logic [1:0]  rw_q;
   logic [15:0] cr_q, latch_q;
   logic        ck_fall, tc, out_d, run_d, take_pend, take_trig;
   logic [15:0] src;
   logic [7:0]  rd_byte;

   assign ck_fall = ck_prev_q & ~count_clk;
   assign tc      = (c.count == 16'h0001);
   assign c.bcd   = bcd_q;
   assign src     = latched_q ? latch_q : c.count;

   // Half of a count for one square-wave phase; odd counts favour high.
   function automatic logic [15:0] half(input logic [15:0] v,
                                        input logic        bcd,
                                        input logic        hi);
      logic [15:0] r;
      logic        cy;
      r  = {1'b0, v[15:1]};
      cy = 1'b0;
      if (bcd) begin
         for (int i = 3; i >= 0; i--) begin
            r[i*4 +: 4] = {1'b0, v[i*4+1 +: 3]} + (cy ? 4'h5 : 4'h0);
            cy          = v[i*4];
         end
      end
      if (v == 16'h0000) begin
         r = bcd ? HALF_MAX_BCD : HALF_MAX_BIN;
      end else if (hi && v[0]) begin
         r = r + 16'h0001;
      end
      return r;
   endfunction

   always_comb begin
      c.load     = 1'b0;
      c.load_val = cr_q;
      c.dec      = 1'b0;
      run_d      = run_q;
      out_d      = out_q;
      take_pend  = 1'b0;
      take_trig  = 1'b0;
      if (ck_fall) begin
         case (mode_q)
            MODE_TC: begin
               if (pend_q && !halt_q) begin
                  c.load    = 1'b1;
                  take_pend = 1'b1;
                  run_d     = 1'b1;
               end else if (run_q && gate && !halt_q) begin
                  c.dec = 1'b1;
                  if (tc) out_d = 1'b1;
               end
            end
            MODE_ONESHT, MODE_HWSTRB: begin
               if (mode_q == MODE_HWSTRB && !out_q) out_d = 1'b1;
               if (trig_q) begin
                  c.load    = 1'b1;
                  take_trig = 1'b1;
                  run_d     = 1'b1;
                  out_d     = (mode_q == MODE_HWSTRB);
               end else if (run_q) begin
                  c.dec = 1'b1;
                  if (tc) begin
                     run_d = 1'b0;
                     out_d = (mode_q == MODE_ONESHT);
                  end
               end
            end
            MODE_RATE: begin
               if (!gate) begin
                  run_d = run_q;
               end else if (trig_q || (pend_q && !run_q)) begin
                  c.load    = 1'b1;
                  take_trig = 1'b1;
                  take_pend = 1'b1;
                  run_d     = 1'b1;
                  out_d     = 1'b1;
               end else if (run_q) begin
                  if (tc) begin
                     c.load    = 1'b1;
                     take_pend = 1'b1;
                     out_d     = 1'b1;
                  end else begin
                     c.dec = 1'b1;
                     if (c.count == 16'h0002) out_d = 1'b0;
                  end
               end
            end
            MODE_SQUARE: begin
               if (!gate) begin
                  run_d = run_q;
               end else if (trig_q || (pend_q && !run_q)) begin
                  c.load     = 1'b1;
                  c.load_val = half(cr_q, bcd_q, 1'b1);
                  take_trig  = 1'b1;
                  take_pend  = 1'b1;
                  run_d      = 1'b1;
                  out_d      = 1'b1;
               end else if (run_q) begin
                  if (tc) begin
                     c.load     = 1'b1;
                     c.load_val = half(cr_q, bcd_q, ~out_q);
                     take_pend  = 1'b1;
                     out_d      = ~out_q;
                  end else begin
                     c.dec = 1'b1;
                  end
               end
            end
            MODE_SWSTRB: begin
               if (!out_q) out_d = 1'b1;
               if (pend_q && !run_q) begin
                  c.load    = 1'b1;
                  take_pend = 1'b1;
                  run_d     = 1'b1;
               end else if (run_q && gate) begin
                  c.dec = 1'b1;
                  if (tc) begin
                     out_d = 1'b0;
                     run_d = 1'b0;
                  end
               end
            end
            default: begin
               run_d = 1'b0;
            end
         endcase
      end
      if ((mode_q == MODE_RATE || mode_q == MODE_SQUARE) && !gate) begin
         out_d = 1'b1;
      end
   end

   down_counter u_cnt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .c       (c)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ck_prev_q   <= 1'b0;
         gate_prev_q <= 1'b0;
      end else begin
         ck_prev_q   <= count_clk;
         gate_prev_q <= gate;
      end
   end

   // Mode set, count writes and counting; bus writes win over consumption.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q  <= MODE_TC;
         bcd_q   <= 1'b0;
         rw_q    <= RW_BOTH;
         cr_q    <= COUNT_RST;
         run_q   <= 1'b0;
         pend_q  <= 1'b0;
         halt_q  <= 1'b0;
         have_q  <= 1'b0;
         trig_q  <= 1'b0;
         out_q   <= 1'b1;
         wr_hi_q <= 1'b0;
      end else begin
         run_q <= run_d;
         out_q <= out_d;
         if (take_pend) pend_q <= 1'b0;
         if (take_trig) trig_q <= 1'b0;
         if (gate && !gate_prev_q && have_q && mode_q != MODE_TC &&
             mode_q != MODE_SWSTRB) begin
            trig_q <= 1'b1;
         end
         if (ctrl_wr && wbyte_q[RW_HIGH_BIT:RW_LOW_BIT] != RW_LATCH) begin
            mode_q  <= (wbyte_q[MODE_MSB] && wbyte_q[MODE_MSB-1]) ?
                       {1'b0, wbyte_q[MODE_MSB-1:MODE_LSB]} :
                       wbyte_q[MODE_MSB:MODE_LSB];
            bcd_q   <= wbyte_q[FMT_BIT];
            rw_q    <= wbyte_q[RW_HIGH_BIT:RW_LOW_BIT];
            run_q   <= 1'b0;
            pend_q  <= 1'b0;
            halt_q  <= 1'b0;
            have_q  <= 1'b0;
            trig_q  <= 1'b0;
            wr_hi_q <= 1'b0;
            out_q   <= (wbyte_q[MODE_MSB:MODE_LSB] != MODE_TC);
         end else if (data_wr) begin
            if (mode_q == MODE_TC) out_q <= 1'b0;
            if (rw_q == RW_BOTH && !wr_hi_q) begin
               cr_q[7:0] <= wbyte_q;
               wr_hi_q   <= 1'b1;
               halt_q    <= (mode_q == MODE_TC);
            end else begin
               if (rw_q == RW_HIGH) cr_q <= {wbyte_q, 8'h00};
               else if (rw_q == RW_LOW) cr_q <= {8'h00, wbyte_q};
               else cr_q[15:8] <= wbyte_q;
               wr_hi_q <= 1'b0;
               pend_q  <= 1'b1;
               have_q  <= 1'b1;
               halt_q  <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path and count latch.
   assign rd_byte = (rw_q == RW_HIGH || (rw_q == RW_BOTH && rd_hi_q)) ?
                    src[15:8] : src[7:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_q   <= COUNT_RST;
         latched_q <= 1'b0;
         rd_hi_q   <= 1'b0;
      end else if (ctrl_wr) begin
         rd_hi_q <= 1'b0;
         if (wbyte_q[RW_HIGH_BIT:RW_LOW_BIT] == RW_LATCH && !latched_q) begin
            latch_q   <= c.count;
            latched_q <= 1'b1;
         end else if (wbyte_q[RW_HIGH_BIT:RW_LOW_BIT] != RW_LATCH) begin
            latched_q <= 1'b0;
         end
      end else if (data_rd) begin
         rd_hi_q <= (rw_q == RW_BOTH) && !rd_hi_q;
         if (rw_q != RW_BOTH || rd_hi_q) latched_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
      end else if (rd_fire) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= RESP_OKAY;
         rdata_q   <= 32'h0000_0000;
         case (araddr)
            CTRL_OFFS:   rdata_q[5:0] <= {rw_q, mode_q, bcd_q};
            DATA_OFFS:   rdata_q[7:0] <= rd_byte;
            STATUS_OFFS: rdata_q <= {c.count, 14'h0000, pend_q, out_q};
            default:     rresp_q <= RESP_SLVERR;
         endcase
      end else if (rvalid_q && rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign awready   = awready_q;
   assign wready    = wready_q;
   assign bvalid    = bvalid_q;
   assign bresp     = bresp_q;
   assign arready   = arready_q;
   assign rvalid    = rvalid_q;
   assign rresp     = rresp_q;
   assign rdata     = rdata_q;
   assign timer_out = out_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_tc_step;
      mode_q == MODE_TC && ck_fall && run_q && gate && !halt_q && !pend_q
         && tc && !ctrl_wr && !data_wr;
   endsequence

   sequence s_strobe_end;
      ck_fall && !out_q && !ctrl_wr && !data_wr
         && (mode_q == MODE_SWSTRB || mode_q == MODE_HWSTRB);
   endsequence

   a_mode0_set_low: assert property (
      ctrl_wr && wbyte_q[RW_HIGH_BIT:RW_LOW_BIT] != RW_LATCH
         && wbyte_q[MODE_MSB:MODE_LSB] == MODE_TC |=> !timer_out)
      else $error("mode 0 set did not drive output low");
   a_mode0_tc_high: assert property (
      s_tc_step |=> timer_out && c.count == 16'h0000)
      else $error("mode 0 terminal count did not raise output");
   a_gate_hold: assert property (
      mode_q == MODE_TC && !gate && !pend_q && !ctrl_wr
         |=> c.count == $past(c.count))
      else $error("mode 0 count moved with gate low");
   a_halt_rewrite: assert property (
      mode_q == MODE_TC && halt_q && !ctrl_wr
         |=> c.count == $past(c.count))
      else $error("mode 0 count moved during rewrite");
   a_oneshot_start: assert property (
      mode_q == MODE_ONESHT && ck_fall && trig_q && !ctrl_wr
         |=> !timer_out && c.count == $past(cr_q))
      else $error("one-shot did not start low from loaded count");
   a_rate_pulse: assert property (
      mode_q == MODE_RATE && ck_fall && gate && run_q && !trig_q
         && c.count == 16'h0002 && !ctrl_wr |=> !timer_out ##1 c.count == 1)
      else $error("rate pulse not produced at count one");
   a_gate_force_hi: assert property (
      (mode_q == MODE_RATE || mode_q == MODE_SQUARE) && !gate && !ctrl_wr
         |=> timer_out)
      else $error("gate low did not force output high");
   a_strobe_one: assert property (
      s_strobe_end |=> timer_out)
      else $error("strobe lasted more than one count clock");
   a_read_low: assert property (
      data_rd && rw_q == RW_BOTH && !rd_hi_q && !latched_q
         |=> rdata_q == {24'h00_0000, $past(c.count[7:0])} ##0 rd_hi_q)
      else $error("two-byte read did not give low byte first");

endmodule

// File: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
   input  wire logic        aclk,    // Clock.
   output      logic [3:0]  awaddr,  // Write address.
   output      logic        awvalid, // Write address valid.
   input  wire logic        awready, // Write address ready.
   output      logic [31:0] wdata,   // Write data.
   output      logic [3:0]  wstrb,   // Byte enables.
   output      logic        wvalid,  // Write data valid.
   input  wire logic        wready,  // Write data ready.
   input  wire logic        bvalid,  // Write response valid.
   output      logic        bready,  // Write response ready.
   output      logic [3:0]  araddr,  // Read address.
   output      logic        arvalid, // Read address valid.
   input  wire logic        arready, // Read address ready.
   input  wire logic        rvalid,  // Read data valid.
   output      logic        rready   // Read data ready.
);
   initial {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
   initial {araddr, arvalid, rready} = '0;

   // Released payloads are inverted so that stale values never match.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
            aw_done = 1'b1;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~wdata;
            w_done = 1'b1;
         end
      end while (!(aw_done && w_done));
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      araddr <= ~a;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
   endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import timer_pkg::*;
   logic        aclk = 0, aresetn = 0, count_clk = 0, gate = 1;
   logic [3:0]  awaddr, wstrb, araddr;
   logic [31:0] wdata, rdata, lfsr_s = 32'h0000_f06b;
   logic [1:0]  rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, timer_out;
   logic [33:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          num_errors = 0, n_compared = 0, cyc = 0, n;

   always #2 aclk = ~aclk;

   interval_timer DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp(), .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .count_clk, .gate, .timer_out);
   host_model hm (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rvalid, .rready);

   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
   endfunction

   task automatic check(input logic [33:0] seen, input logic [33:0] ex);
      n_compared++;
      if (seen !== ex) begin
         num_errors++;
         $display("BAD %0t: got %h want %h", $time, seen, ex);
      end
   endtask

   task automatic rd(input logic [3:0] a, input logic [33:0] e,
                     input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      hm.rd(a);
   endtask

   task automatic st(input logic [15:0] c, input logic o, input logic f);
      rd(STATUS_OFFS, {2'h0, c, 15'h0000, o}, f ? 32'hffff_0001 : 1);
   endtask

   task automatic tick(input int k);
      repeat (k) begin
         count_clk <= 1'b1;
         repeat (4) @(posedge aclk);
         count_clk <= 1'b0;
         repeat (4) @(posedge aclk);
      end
   endtask

   task automatic gate_pulse;
      gate <= 1'b0;
      repeat (2) @(posedge aclk);
      gate <= 1'b1;
   endtask

   task give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         if (exp_q.size() == 0) begin
            check(34'h0_0000_0000, 34'h3_ffff_ffff);
         end else begin
            check({rresp, rdata & msk_q[0]}, exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
         end
      end
   end

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict;
      end
   end

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      hm.wr(CTRL_OFFS, 8'h30);
      st(16'h0000, 1'b0, 1'b0);
      hm.wr(DATA_OFFS, 8'h05);
      hm.wr(DATA_OFFS, 8'h01);
      tick(3);
      hm.wr(CTRL_OFFS, 8'h00);
      rd(DATA_OFFS, 34'h0_0000_0003, 32'hffff_ffff);
      rd(DATA_OFFS, 34'h0_0000_0001, 32'hffff_ffff);
      hm.wr(DATA_OFFS, 8'h05);
      tick(2);
      st(16'h0103, 1'b0, 1'b1);
      hm.wr(DATA_OFFS, 8'h01);
      tick(1);
      gate <= 1'b0;
      tick(2);
      st(16'h0105, 1'b0, 1'b1);
      gate <= 1'b1;
      tick(16'h0104);
      st(16'h0001, 1'b0, 1'b1);
      tick(1);
      st(16'h0000, 1'b1, 1'b1);
      rd(4'hc, {RESP_SLVERR, 32'h0000_0000}, 32'h0000_0000);
      $display("terminal count test done");
      for (int m = 2; m < 4; m++) begin
         n = 3 + int'(lfsr_s[1:0]);
         lfsr_s = lfsr(lfsr_s);
         hm.wr(CTRL_OFFS, 8'h30 | 8'(m * 2));
         st(16'h0000, 1'b1, 1'b0);
         hm.wr(DATA_OFFS, 8'(n));
         hm.wr(DATA_OFFS, 8'h00);
         for (int i = 0; i <= 3 * n - 1; i++) begin
            tick(1);
            st(16'h0000, m == 2 ? (i % n) != n - 1 : (i % n) < (n + 1) / 2,
               1'b0);
         end
         gate <= 1'b0;
         repeat (2) @(posedge aclk);
         st(16'h0000, 1'b1, 1'b0);
         gate <= 1'b1;
         $display("periodic mode test done");
      end
      for (int m = 1; m < 6; m++) begin
         if (m == 2 || m == 3) continue;
         hm.wr(CTRL_OFFS, 8'h30 | 8'(m * 2));
         hm.wr(DATA_OFFS, 8'h03);
         hm.wr(DATA_OFFS, 8'h00);
         if (m != 4) gate_pulse;
         for (int i = 1; i <= 7; i++) begin
            tick(1);
            if (m != 4 && i == 2) gate_pulse;
            if ((m == 4 && i == 2) || (m == 1 && i == 4)) begin
               hm.wr(DATA_OFFS, 8'h05);
               hm.wr(DATA_OFFS, 8'h00);
            end
            if (m == 1 && i == 5) begin
               rd(DATA_OFFS, 34'h0_0000_0001, 32'hffff_ffff);
               rd(DATA_OFFS, 34'h0_0000_0000, 32'hffff_ffff);
            end
            st(16'h0000, m == 1 ? i > 5 : i != (m == 4 ? 4 : 6),
               1'b0);
         end
         $display("strobe mode test done");
      end
      repeat (8) @(posedge aclk);
      give_verdict;
   end
endmodule
